// >>> pkg/cfg_hdr_pkg.sv
// Shared constants and carrier types for the configuration header block.
package cfg_hdr_pkg;

  // Number of base registers in the header.
  localparam int BAR_COUNT = 6;

  // Byte offsets of the base registers in configuration space.
  localparam logic [7:0] OFF_BAR [BAR_COUNT] =
    '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};

  // Byte offset of the subsystem identifier register.
  localparam logic [7:0] OFF_SSID = 8'h2c;

  // Byte offset of the configuration control register.
  localparam logic [7:0] OFF_CFGCTL = 8'h40;

  // Position of the header write-enable bit in the control register.
  localparam int HDR_WE_BIT = 0;

  // Lowest writable bit of each base register.
  localparam int unsigned BAR_LOW [BAR_COUNT] = '{3, 2, 3, 2, 4, 8};

  // Writable bits of each base register.
  localparam logic [31:0] BAR_WMASK [BAR_COUNT] =
    '{32'hffff_fff8, 32'hffff_fffc, 32'hffff_fff8,
      32'hffff_fffc, 32'hffff_fff0, 32'hffff_ff00};

  // Reset value of each base register; it equals the hardwired low bits.
  localparam logic [31:0] BAR_RESET [BAR_COUNT] =
    '{32'h0000_0001, 32'h0000_0001, 32'h0000_0001,
      32'h0000_0001, 32'h0000_0001, 32'h0000_0000};

  // Index of the memory window base register.
  localparam int MEM_BAR = 5;

  // Signature words of a valid serial EEPROM image.
  localparam logic [15:0] EE_SIG_HI = 16'h55aa;
  localparam logic [15:0] EE_SIG_LO = 16'h55aa;

  // Signature word and byte of a valid flash image.
  localparam logic [15:0] FL_SIG_WORD = 16'haa55;
  localparam logic [7:0] FL_SIG_BYTE = 8'h55;

  // Loader states, Gray coded along wait, check, done.
  typedef enum logic [1:0] {
    LD_WAIT = 2'b00,
    LD_CHECK = 2'b01,
    LD_DONE = 2'b11
  } ld_state_t;

  // One configuration access; byte enables are active high.
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  // Image fetched from the external memory by the load sequencer.
  typedef struct packed {
    logic is_flash;
    logic [15:0] sig_hi;
    logic [15:0] sig_lo;
    logic [31:0] ident;
  } nvm_img_t;

endpackage : cfg_hdr_pkg

// >>> hdl/bar_window_match.sv
// Address comparator for one base register window.
module bar_window_match #(
  parameter int unsigned LOW = 3
) (
  input wire logic [31:0] base,
  input wire logic [31:0] addr,
  input wire logic enable,
  output logic hit
);

  // Only the writable upper bits take part; the low bits span the window.
  assign hit = enable && (addr[31:LOW] == base[31:LOW]);

endmodule : bar_window_match

// >>> hdl/pci_bar_subsys_id_config.sv
// Base registers and subsystem identifier of the configuration header.
//
// Contract
// - BAR0 bits 31:3 writable, low reads 001.
// - BAR1 bits 31:2 writable, low reads 01.
// - BAR2 bits 31:3 writable, low reads 001.
// - BAR3 bits 31:2 writable, low reads 01.
// - BAR4 bits 31:4 writable, low reads 0001.
// - BAR5 bits 31:8 writable, low reads zero.
// - BAR5 exists only with strap high.
// - Subsystem_identity high, vendor low, read-only while write-enable clear.
// - Hardwired default codes absent other source.
// - Valid memory image replaces defaults after reset.
// - EEPROM valid only with 55aa signature pair.
// - Flash valid only with aa55 and 55.
// - Control bit 0 unlocks identifier field writes.
// - Write-enable bit unlocks header identity fields.
module pci_bar_subsys_id_config #(
  // Default subsystem identifier; the value is arbitrary.
  parameter logic [15:0] DEFAULT_SUBSYS_ID = 16'h5a01,
  // Default subsystem vendor identifier; the value is arbitrary.
  parameter logic [15:0] DEFAULT_SUBSYS_VENDOR = 16'h5a02
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfg_valid,
  input wire cfg_hdr_pkg::cfg_req_t cfg_req,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic memory_window_strap,
  input wire logic nvm_valid,
  input wire cfg_hdr_pkg::nvm_img_t nvm_img,
  input wire logic io_req,
  input wire logic [31:0] io_addr,
  input wire logic io_space_en,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_space_en,
  output logic [4:0] io_hit,
  output logic mem_hit,
  output logic hdr_wr_en,
  output logic ident_loaded
);

  // Complete state of the block in one record.
  typedef struct packed {
    logic [cfg_hdr_pkg::BAR_COUNT-1:0][31:0] bar;
    logic [31:0] ssid;
    logic hdr_we;
    cfg_hdr_pkg::ld_state_t ld;
    cfg_hdr_pkg::nvm_img_t img;
    logic loaded;
    logic ack;
    logic [31:0] rdata;
    logic [4:0] io_hit;
    logic mem_hit;
  } state_t;

  // Registered state and its next value.
  state_t s_q;
  state_t s_d;

  // Raw window comparisons, one per base register.
  logic [cfg_hdr_pkg::BAR_COUNT-1:0] win_hit;

  // Merges write data into a word under byte enables.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // Checks the signature of an image for its memory type.
  function automatic logic sig_ok(input cfg_hdr_pkg::nvm_img_t img);
    logic ok;
    if (img.is_flash) begin
      // Word at the top of flash plus the byte two below it.
      ok = (img.sig_hi == cfg_hdr_pkg::FL_SIG_WORD) &&
           (img.sig_lo[7:0] == cfg_hdr_pkg::FL_SIG_BYTE);
    end else begin
      // Two words at the very start of the EEPROM.
      ok = (img.sig_hi == cfg_hdr_pkg::EE_SIG_HI) &&
           (img.sig_lo == cfg_hdr_pkg::EE_SIG_LO);
    end
    return ok;
  endfunction : sig_ok

  // One comparator per window; the memory window follows its strap.
  for (genvar g = 0; g < cfg_hdr_pkg::BAR_COUNT; g++) begin : g_win
    bar_window_match #(
      .LOW(cfg_hdr_pkg::BAR_LOW[g])
    ) u_win (
      .base(s_q.bar[g]),
      .addr((g == cfg_hdr_pkg::MEM_BAR) ? mem_addr : io_addr),
      .enable((g == cfg_hdr_pkg::MEM_BAR) ? memory_window_strap : 1'b1),
      .hit(win_hit[g])
    );
  end

  // Next-state logic: configuration access, loader and window claims.
  always_comb begin
    logic [5:0] dw;
    logic [31:0] merged;
    dw = cfg_req.addr[7:2];
    merged = 32'h0000_0000;
    s_d = s_q;
    s_d.ack = 1'b0;

    // Every configuration access is answered one cycle later.
    if (cfg_valid) begin
      s_d.ack = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (dw == cfg_hdr_pkg::OFF_CFGCTL[7:2]) begin
        // Only bit 0 exists; the rest reads as zero.
        s_d.rdata[cfg_hdr_pkg::HDR_WE_BIT] = s_q.hdr_we;
        if (cfg_req.wr && cfg_req.be[0]) begin
          s_d.hdr_we = cfg_req.wdata[cfg_hdr_pkg::HDR_WE_BIT];
        end
      end else if (dw == cfg_hdr_pkg::OFF_SSID[7:2]) begin
        // Identifier high half, vendor low half.
        s_d.rdata = s_q.ssid;
        if (cfg_req.wr && s_q.hdr_we) begin
          // Writes land only while the header is unlocked.
          s_d.ssid = merge_bytes(s_q.ssid, cfg_req.wdata,
                                 cfg_req.be);
        end
      end else begin
        // Base registers; other offsets read zero and drop writes.
        for (int i = 0; i < cfg_hdr_pkg::BAR_COUNT; i++) begin
          if ((dw == cfg_hdr_pkg::OFF_BAR[i][7:2]) &&
              ((i != cfg_hdr_pkg::MEM_BAR) || memory_window_strap)) begin
            // An absent memory window reads zero and ignores writes.
            s_d.rdata = s_q.bar[i];
            if (cfg_req.wr) begin
              merged = merge_bytes(s_q.bar[i], cfg_req.wdata, cfg_req.be);
              // Hardwired low bits are forced back on every write.
              s_d.bar[i] = (merged & cfg_hdr_pkg::BAR_WMASK[i]) |
                cfg_hdr_pkg::BAR_RESET[i];
            end
          end
        end
      end
    end

    // Loader: one image after reset, checked a cycle after capture.
    case (s_q.ld)
      cfg_hdr_pkg::LD_WAIT: begin
        if (nvm_valid) begin
          s_d.img = nvm_img;
          s_d.ld = cfg_hdr_pkg::LD_CHECK;
        end
      end
      cfg_hdr_pkg::LD_CHECK: begin
        // A good image wins over a software write in the same cycle.
        if (sig_ok(s_q.img)) begin
          s_d.ssid = s_q.img.ident;
          s_d.loaded = 1'b1;
        end
        s_d.ld = cfg_hdr_pkg::LD_DONE;
      end
      default: begin
        // Done: later images are ignored until the next reset.
        s_d.ld = cfg_hdr_pkg::LD_DONE;
      end
    endcase

    // Claims are registered so the outputs come straight from flops.
    s_d.io_hit = (io_req && io_space_en) ? win_hit[4:0] : 5'h00;
    s_d.mem_hit = mem_req && mem_space_en &&
                  win_hit[cfg_hdr_pkg::MEM_BAR];
  end

  // State register; reset takes constants only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < cfg_hdr_pkg::BAR_COUNT; i++) begin
        s_q.bar[i] <= cfg_hdr_pkg::BAR_RESET[i];
      end
      // Defaults hold until an image or software replaces them.
      s_q.ssid <= {DEFAULT_SUBSYS_ID, DEFAULT_SUBSYS_VENDOR};
      s_q.hdr_we <= 1'b0;
      s_q.ld <= cfg_hdr_pkg::LD_WAIT;
      s_q.img <= '0;
      s_q.loaded <= 1'b0;
      s_q.ack <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.io_hit <= 5'h00;
      s_q.mem_hit <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs are plain copies of registered state.
  assign cfg_ack = s_q.ack;
  assign cfg_rdata = s_q.rdata;
  assign io_hit = s_q.io_hit;
  assign mem_hit = s_q.mem_hit;
  assign hdr_wr_en = s_q.hdr_we;
  assign ident_loaded = s_q.loaded;

  // Helpers that only the checks below read.
  logic wr_full;
  logic rd_any;
  assign wr_full = cfg_valid && cfg_req.wr && (cfg_req.be == 4'hf);
  assign rd_any = cfg_valid && !cfg_req.wr;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Full write to the first task file base keeps 001 below it.
  a_tf0_bar_write: assert property (
    wr_full && cfg_req.addr == cfg_hdr_pkg::OFF_BAR[0] |=>
    s_q.bar[0] == (($past(cfg_req.wdata) & 32'hffff_fff8) | 32'h1))
    else $error("task file base 0 write wrong");

  // Control base of channel 0 keeps 01 and is read back.
  a_ctl0_bar_rw: assert property (
    wr_full && cfg_req.addr == cfg_hdr_pkg::OFF_BAR[1] ##1
    rd_any && cfg_req.addr == cfg_hdr_pkg::OFF_BAR[1] |=>
    cfg_ack && cfg_rdata == (($past(cfg_req.wdata, 2) &
    32'hffff_fffc) | 32'h1))
    else $error("control base 0 read-back wrong");

  // Second task file base masks like the first.
  a_tf1_bar_write: assert property (
    wr_full && cfg_req.addr == cfg_hdr_pkg::OFF_BAR[2] |=>
    s_q.bar[2] == (($past(cfg_req.wdata) & 32'hffff_fff8) | 32'h1))
    else $error("task file base 1 write wrong");

  // Control base of channel 1 never loses its low pattern.
  a_ctl1_low_bits: assert property (
    wr_full && cfg_req.addr == cfg_hdr_pkg::OFF_BAR[3] |=>
    s_q.bar[3][1:0] == 2'b01 &&
    s_q.bar[3][31:2] == $past(cfg_req.wdata[31:2]))
    else $error("control base 1 write wrong");

  // Bus-master base keeps 0001 below bit 4.
  a_bm_bar_write: assert property (
    wr_full && cfg_req.addr == cfg_hdr_pkg::OFF_BAR[4] |=>
    s_q.bar[4] == (($past(cfg_req.wdata) & 32'hffff_fff0) | 32'h1))
    else $error("bus-master base write wrong");

  // Memory base clears its low byte when present.
  a_mem_bar_write: assert property (
    wr_full && memory_window_strap &&
    cfg_req.addr == cfg_hdr_pkg::OFF_BAR[5] |=>
    s_q.bar[5] == ($past(cfg_req.wdata) & 32'hffff_ff00))
    else $error("memory base write wrong");

  // Without the strap the memory base reads zero and never claims.
  a_mem_bar_gate: assert property (
    rd_any && !memory_window_strap &&
    cfg_req.addr == cfg_hdr_pkg::OFF_BAR[5] |=>
    cfg_ack && cfg_rdata == 32'h0 && !mem_hit)
    else $error("absent memory base visible");

  // Identifier read returns the held value a cycle later.
  a_ssid_read: assert property (
    rd_any && cfg_req.addr == cfg_hdr_pkg::OFF_SSID |=>
    cfg_ack && cfg_rdata == $past(s_q.ssid))
    else $error("identifier read wrong");

  // Locked header ignores identifier writes.
  a_ssid_locked: assert property (
    cfg_valid && cfg_req.wr && !s_q.hdr_we &&
    s_q.ld != cfg_hdr_pkg::LD_CHECK &&
    cfg_req.addr == cfg_hdr_pkg::OFF_SSID |=> $stable(s_q.ssid))
    else $error("identifier changed while locked");

  // Unlocked header takes a full identifier write.
  a_ssid_unlocked: assert property (
    wr_full && s_q.hdr_we && s_q.ld != cfg_hdr_pkg::LD_CHECK &&
    cfg_req.addr == cfg_hdr_pkg::OFF_SSID |=>
    s_q.ssid == $past(cfg_req.wdata))
    else $error("unlocked identifier write lost");

  // A good image lands within one cycle of capture.
  a_sig_accept: assert property (
    s_q.ld == cfg_hdr_pkg::LD_CHECK && sig_ok(s_q.img) |=>
    ident_loaded && s_q.ssid == $past(s_q.img.ident))
    else $error("valid image not loaded");

  // A bad signature leaves the identifier alone.
  a_sig_reject: assert property (
    s_q.ld == cfg_hdr_pkg::LD_CHECK && !sig_ok(s_q.img) &&
    !s_q.loaded && !cfg_valid |=> !ident_loaded && $stable(s_q.ssid))
    else $error("invalid image accepted");

  // An I/O access inside the first window is claimed next cycle.
  a_io_window_hit: assert property (
    io_req && io_space_en && io_addr[31:3] == s_q.bar[0][31:3] |=>
    io_hit[0])
    else $error("task file window not claimed");

  // The write-enable bit follows a write to the control register.
  a_hdr_we_write: assert property (
    cfg_valid && cfg_req.wr && cfg_req.be[0] &&
    cfg_req.addr == cfg_hdr_pkg::OFF_CFGCTL |=>
    hdr_wr_en == $past(cfg_req.wdata[0]))
    else $error("header write enable not taken");

  // A memory access inside the present memory window is claimed.
  a_mem_window_hit: assert property (
    mem_req && mem_space_en && memory_window_strap &&
    mem_addr[31:8] == s_q.bar[cfg_hdr_pkg::MEM_BAR][31:8] |=> mem_hit)
    else $error("memory window not claimed");

  // With I/O space off no I/O window is ever claimed.
  a_io_space_off: assert property (
    !io_space_en |=> io_hit == 5'h00)
    else $error("claim with I/O space off");

  // Hardwired low bits of every base register never move.
  a_bar_low_fixed: assert property (
    s_q.bar[0][2:0] == 3'b001 && s_q.bar[1][1:0] == 2'b01 &&
    s_q.bar[2][2:0] == 3'b001 && s_q.bar[3][1:0] == 2'b01 &&
    s_q.bar[4][3:0] == 4'b0001 && s_q.bar[5][7:0] == 8'h00)
    else $error("hardwired base bits moved");

  // Only the first image after reset is looked at; later ones are dropped.
  a_loader_once: assert property (
    s_q.ld == cfg_hdr_pkg::LD_DONE |=>
    s_q.ld == cfg_hdr_pkg::LD_DONE && $stable(ident_loaded))
    else $error("loader ran twice");

  // Main scenarios worth seeing.
  c_eeprom_load: cover property (
    s_q.ld == cfg_hdr_pkg::LD_CHECK && !s_q.img.is_flash ##1 ident_loaded);
  c_flash_load: cover property (
    s_q.ld == cfg_hdr_pkg::LD_CHECK && s_q.img.is_flash ##1 ident_loaded);
  c_mem_claim: cover property (mem_hit);
  c_back_to_back: cover property (wr_full ##1 rd_any);
  c_soft_ssid: cover property (
    wr_full && s_q.hdr_we && cfg_req.addr == cfg_hdr_pkg::OFF_SSID);

endmodule : pci_bar_subsys_id_config

// >>> bench/pci_host_model.sv
// Behavioural host bridge that issues configuration cycles.
module pci_host_model (
  input wire logic clk,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  output logic cfg_valid,
  output cfg_hdr_pkg::cfg_req_t cfg_req
);
  timeunit 1ns;
  timeprecision 100ps;

  // Answers that never came within the bound.
  int timeouts = 0;

  initial begin
    cfg_valid = 1'b0;
    cfg_req = '0;
  end

  // One access: a one-cycle request, then the answer at a later edge.
  task automatic access(input logic wr, input logic [7:0] addr,
    input logic [3:0] be, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    @(posedge clk);
    #1;
    cfg_valid = 1'b1;
    cfg_req = '{wr, addr, be, wd};
    @(posedge clk);
    #1;
    cfg_valid = 1'b0;
    // Inverted so that stale fields never pass for a live request.
    cfg_req = ~cfg_req;
    for (n = 0; n < 4; n++) begin
      @(posedge clk);
      if (cfg_ack === 1'b1) break;
    end
    if (n == 4) timeouts++;
    rd = cfg_rdata;
  endtask : access

  // A full write and a read of one address on two consecutive edges.
  task automatic wr_rd(input logic [7:0] addr, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    @(posedge clk);
    #1;
    cfg_valid = 1'b1;
    cfg_req = '{1'b1, addr, 4'hf, wd};
    @(posedge clk);
    #1;
    cfg_req = '{1'b0, addr, 4'hf, ~wd};
    @(posedge clk);
    #1;
    cfg_valid = 1'b0;
    cfg_req = ~cfg_req;
    // The write's answer has passed; the read's stands at the next edge.
    for (n = 0; n < 4; n++) begin
      @(posedge clk);
      if (cfg_ack === 1'b1) break;
    end
    if (n == 4) timeouts++;
    rd = cfg_rdata;
  endtask : wr_rd
endmodule : pci_host_model

// >>> bench/tb_top.sv
// Self-checking bench for the base registers and subsystem identifier.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // Default identifier codes; the values are arbitrary.
  localparam logic [15:0] DEF_ID = 16'h3c11;
  localparam logic [15:0] DEF_VEN = 16'h3c22;

  logic clk, rst_n, cfg_valid, cfg_ack, memory_window_strap;
  logic nvm_valid, io_req, io_space_en, mem_req, mem_space_en;
  logic mem_hit, hdr_wr_en, ident_loaded, good;
  cfg_hdr_pkg::cfg_req_t cfg_req;
  cfg_hdr_pkg::nvm_img_t nvm_img, img;
  logic [31:0] cfg_rdata, io_addr, mem_addr, rd, w;
  logic [31:0] bars [6];
  logic [5:0] h;
  logic [4:0] io_hit;
  logic [3:0] be;
  int i;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 32'ha185df4b;

  pci_bar_subsys_id_config #(.DEFAULT_SUBSYS_ID(DEF_ID),
    .DEFAULT_SUBSYS_VENDOR(DEF_VEN)) u_pci_bar_subsys_id_config (
    .clk(clk), .rst_n(rst_n), .cfg_valid(cfg_valid),
    .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .memory_window_strap(memory_window_strap),
    .nvm_valid(nvm_valid), .nvm_img(nvm_img), .io_req(io_req),
    .io_addr(io_addr), .io_space_en(io_space_en), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_space_en(mem_space_en),
    .io_hit(io_hit), .mem_hit(mem_hit), .hdr_wr_en(hdr_wr_en),
    .ident_loaded(ident_loaded));

  pci_host_model u_pci_host_model (.clk(clk), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .cfg_valid(cfg_valid), .cfg_req(cfg_req));

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // Byte-enable merge of a write into an old word.
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
    logic [3:0] b);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    return (o & ~m) | (n & m);
  endfunction : merge

  // Windows that an address falls into, by the writable base bits.
  function automatic logic [5:0] hits(logic [31:0] a);
    logic [5:0] r;
    for (int j = 0; j < 6; j++) begin
      r[j] = ((a ^ bars[j]) & cfg_hdr_pkg::BAR_WMASK[j]) == 32'h0;
    end
    r[5] = r[5] & memory_window_strap;
    return r;
  endfunction : hits

  // Holds reset for ten cycles, moving off the clock edge first.
  task automatic do_reset;
    #1;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int j = 0; j < 6; j++) bars[j] = cfg_hdr_pkg::BAR_RESET[j];
  endtask : do_reset

  task automatic wr_reg(input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d);
    logic [31:0] x;
    u_pci_host_model.access(1'b1, a, b, d, x);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    u_pci_host_model.access(1'b0, a, 4'hf, 32'h0, rd);
  endtask : rd_reg

  // Writes base register i and tracks what it must then hold.
  task automatic bar_write(input int k, input logic [3:0] b,
    input logic [31:0] d);
    wr_reg(cfg_hdr_pkg::OFF_BAR[k], b, d);
    bars[k] = merge(bars[k], d, b) & cfg_hdr_pkg::BAR_WMASK[k]
      | cfg_hdr_pkg::BAR_RESET[k];
    rd_reg(cfg_hdr_pkg::OFF_BAR[k]);
    check("bar", rd, bars[k]);
  endtask : bar_write

  // Presents one address to both window probes for one cycle.
  task automatic probe(input logic [31:0] a, input logic en);
    @(posedge clk);
    #1;
    h = en ? hits(a) : 6'h0;
    {io_req, io_space_en, io_addr} = {1'b1, en, a};
    {mem_req, mem_space_en, mem_addr} = {1'b1, en, a};
    @(posedge clk);
    #1;
    {io_req, mem_req, io_addr, mem_addr} = {2'b00, ~a, ~a};
    check("io hit", {27'h0, io_hit}, {27'h0, h[4:0]});
    check("mem hit", {31'h0, mem_hit}, {31'h0, h[5]});
  endtask : probe

  // Hands one image from the external memory to the loader.
  task automatic send_img(input cfg_hdr_pkg::nvm_img_t m);
    @(posedge clk);
    #1;
    nvm_valid = 1'b1;
    nvm_img = m;
    @(posedge clk);
    #1;
    nvm_valid = 1'b0;
    nvm_img = ~m;
  endtask : send_img

  // Cuts a hang short.
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    {rst_n, memory_window_strap, nvm_valid, nvm_img} = '0;
    {io_req, io_space_en, io_addr, mem_req, mem_space_en, mem_addr} = '0;
    do_reset();
    for (i = 0; i < 6; i++) begin
      rd_reg(cfg_hdr_pkg::OFF_BAR[i]);
      check("bar reset", rd, bars[i]);
    end
    // Strap low hides the memory base and drops writes to it.
    wr_reg(8'h24, 4'hf, 32'h1234_5600);
    rd_reg(8'h24);
    check("hidden bar", rd, 32'h0);
    #1;
    memory_window_strap = 1'b1;
    for (i = 0; i < 6; i++) bar_write(i, 4'hf, 32'hffff_ffff);
    // A read right behind a write must already see the new value.
    w = $random(seed);
    u_pci_host_model.wr_rd(cfg_hdr_pkg::OFF_BAR[1], w, rd);
    bars[1] = w & cfg_hdr_pkg::BAR_WMASK[1] | cfg_hdr_pkg::BAR_RESET[1];
    check("bar back to back", rd, bars[1]);
    repeat (60) begin
      i = $unsigned($random(seed)) % 6;
      bar_write(i, $random(seed), $random(seed));
      w = (bars[i] & cfg_hdr_pkg::BAR_WMASK[i]) | $random(seed);
      probe(w & ~cfg_hdr_pkg::BAR_WMASK[i] | bars[i], 1'b1);
      probe(w ^ 32'h8000_0000, 1'b1);
      probe(bars[i], 1'b0);
    end
    memory_window_strap = 1'b0;
    probe(bars[5], 1'b1);
    rd_reg(8'h30);
    check("unmapped", rd, 32'h0);
    // Identifier is read-only until the header write enable is set.
    rd_reg(cfg_hdr_pkg::OFF_SSID);
    check("ident default", rd, {DEF_ID, DEF_VEN});
    wr_reg(cfg_hdr_pkg::OFF_SSID, 4'hf, 32'hdead_beef);
    rd_reg(cfg_hdr_pkg::OFF_SSID);
    check("ident locked", rd, {DEF_ID, DEF_VEN});
    wr_reg(cfg_hdr_pkg::OFF_CFGCTL, 4'h1, 32'h1);
    check("wr en", {31'h0, hdr_wr_en}, 32'h1);
    rd_reg(cfg_hdr_pkg::OFF_CFGCTL);
    check("wr en read", rd, 32'h1);
    w = $random(seed);
    be = $random(seed);
    wr_reg(cfg_hdr_pkg::OFF_SSID, be, w);
    rd_reg(cfg_hdr_pkg::OFF_SSID);
    check("ident open", rd, merge({DEF_ID, DEF_VEN}, w, be));
    // Clearing the enable locks the identifier again.
    wr_reg(cfg_hdr_pkg::OFF_CFGCTL, 4'h1, 32'h0);
    wr_reg(cfg_hdr_pkg::OFF_SSID, 4'hf, ~w);
    rd_reg(cfg_hdr_pkg::OFF_SSID);
    check("ident relocked", rd, merge({DEF_ID, DEF_VEN}, w, be));
    // Loader cases: good and broken images of both memory kinds.
    for (i = 0; i < 6; i++) begin
      do_reset();
      img.ident = $random(seed);
      img.is_flash = i > 2;
      // EEPROM pattern on cases 0, 1 and 5, flash pattern on 2, 3 and 4.
      img.sig_hi = (i < 2 || i == 5) ? 16'h55aa : 16'haa55;
      img.sig_lo = i > 2 ? {8'($random(seed)), i == 4 ? 8'h54 : 8'h55}
        : (i == 1 ? 16'h55ab : 16'h55aa);
      good = (i == 0) || (i == 3);
      send_img(img);
      repeat (2) @(posedge clk);
      #1;
      check("loaded", {31'h0, ident_loaded}, {31'h0, good});
      send_img('{1'b0, 16'h55aa, 16'h55aa, ~img.ident});
      rd_reg(cfg_hdr_pkg::OFF_SSID);
      check("ident", rd, good ? img.ident : {DEF_ID, DEF_VEN});
    end
    check("answers", u_pci_host_model.timeouts, 32'h0);
    wrap_up();
  end
endmodule : tb_top
